// ===== src/ep_ring_regs.vh
// register map, field positions, reset values and timing for the endpoint ring engine
`ifndef EP_RING_REGS_VH
`define EP_RING_REGS_VH
`define F_DESC      3'h0
`define F_BASE      3'h1
`define F_SIZE      3'h2
`define F_RDOFF     3'h3
`define F_WROFF     3'h4
`define F_NAKLIM    3'h5
`define A_GLOBAL    1'b1
`define A_CTRL      6'h00
`define A_DLADDR1   6'h01
`define A_DLADDR2   6'h02
`define A_DLADDR3   6'h03
`define A_STATUS    6'h04
`define DESC_DIR    0
`define DESC_MPK_HI 7
`define DESC_MPK_LO 1
`define INIT_ALL    5'h1F
`define RST_OFF     16'h0000
`define FIRST_GEN   4'h4
`define LAST_GEN    4'hB
`define CLK_NS      100
`define DETACH_NS   10000
`define DETACH_CYC  ((`DETACH_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== src/ep_fifo.v
// synchronous valid/ready fifo between memory fetch and serial engine
`timescale 1ns/1ps
module ep_fifo #(
    parameter W  = 17,
    parameter D  = 32,
    parameter AW = 5
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          inValid,
    output wire          inReady,
    input  wire [W-1:0]  inData,
    output wire          outValid,
    input  wire          outReady,
    output wire [W-1:0]  outData
);
    reg [W-1:0] mem [0:D-1];
    reg [AW:0]  wp_r;
    reg [AW:0]  rp_r;
    wire        full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire        empty = (wp_r == rp_r);
    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = mem[rp_r[AW-1:0]];
    always @(posedge clk) begin
        if (rst) begin
            wp_r <= {(AW+1){1'b0}};
            rp_r <= {(AW+1){1'b0}};
        end else begin
            if (inValid && !full) begin
                mem[wp_r[AW-1:0]] <= inData;
                wp_r <= wp_r + 1'b1;
            end
            if (outReady && !empty)
                rp_r <= rp_r + 1'b1;
        end
    end
endmodule // ep_fifo

// ===== src/ep_ring_engine.v
// ring-buffer dma engine for generic usb endpoints into dsp memory
// Operation
// - hardware moves all generic endpoint data
// - per-endpoint base, size, read, write offsets
// - generic transfers use whole 16-bit words
// - control endpoint may write single bytes
// - pointer ownership split by direction
// - offsets start zero, wrap at end
// - data available from write/read difference
// - full packet stored: ack, commit write
// - pointer collision: nak, keep write offset
// - oversize packet accepted if room
// - in token sends full packet when one is ready
// - read offset advances after host ack
// - short packet after programmed nak count
// - endpoint idle until five registers written
// - code download only after firmware personality
// - attach first as setup personality
// - control register write detaches, reattaches
// - drop zero low byte of instruction
`timescale 1ns/1ps
`include "ep_ring_regs.vh"
module ep_ring_engine #(
    parameter DETACH_CYCLES = `DETACH_CYC,
    parameter FIFO_DEPTH    = 32,
    parameter FIFO_AW       = 5
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        regWr,
    input  wire        regRd,
    input  wire [6:0]  regAddr,
    input  wire [17:0] regWrData,
    output reg  [17:0] regRdData_r,
    input  wire        fwLoaded,
    output reg         busAttach_r,
    output reg         firmwareMode_r,
    input  wire        tokenValid,
    input  wire [3:0]  tokenEp,
    input  wire        tokenIn,
    input  wire        rxValid,
    input  wire [15:0] rxData,
    input  wire        rxLast,
    output reg         rxReady_r,
    output reg         hsAck_r,
    output reg         hsNak_r,
    output wire        txValid,
    output wire [15:0] txData,
    output wire        txLast,
    input  wire        txReady,
    input  wire        hostAck,
    input  wire        hostTimeout,
    input  wire        ep0Req,
    input  wire [17:0] ep0Addr,
    input  wire [15:0] ep0Data,
    input  wire [1:0]  ep0ByteEn,
    output reg         ep0Done_r,
    output reg         memReq_r,
    output reg         memWe_r,
    output reg  [17:0] memAddr_r,
    output reg  [15:0] memWdata_r,
    output reg  [1:0]  memByteEn_r,
    input  wire [15:0] memRdata,
    input  wire        memAck,
    output reg         pmWe_r,
    output reg  [15:0] pmAddr_r,
    output reg  [23:0] pmData_r
);
    localparam S_IDLE = 3'd0;
    localparam S_OUT  = 3'd1;
    localparam S_IN   = 3'd2;
    localparam S_INW  = 3'd3;
    localparam S_DL   = 3'd4;
    localparam S_EP0  = 3'd5;

    reg [7:0]  desc_r [0:7];
    reg [17:0] base_r [0:7];
    reg [15:0] size_r [0:7];
    reg [15:0] rdOff_r [0:7];
    reg [15:0] wrOff_r [0:7];
    reg [3:0]  nakLim_r [0:7];
    reg [3:0]  nakCnt_r [0:7];
    reg [4:0]  init_r [0:7];
    reg [15:0] dlAddr_r [0:2];
    reg [2:0]  st_r;
    reg [2:0]  ep_r;
    reg [15:0] ptr_r;
    reg [15:0] cnt_r;
    reg        coll_r;
    reg        outLast_r;
    reg        half_r;
    reg [7:0]  hi_r;
    reg [1:0]  dl_r;
    reg [15:0] detCnt_r;
    reg        pushV;
    integer    i;

    wire [2:0]  tEp   = tokenEp[2:0] - 3'd4;
    wire        tGen  = (tokenEp >= `FIRST_GEN) && (tokenEp <= `LAST_GEN);
    wire        tDl   = (tokenEp != 4'h0) && (tokenEp < `FIRST_GEN);
    wire [15:0] sz    = size_r[ep_r];
    wire [15:0] rdC   = rdOff_r[ep_r];
    wire [15:0] wrC   = wrOff_r[ep_r];
    wire [15:0] ptrN  = (ptr_r + 16'h0001 == sz) ? `RST_OFF : ptr_r + 16'h0001;
    wire [17:0] mAddr = base_r[ep_r] + {2'b00, ptr_r};
    // max packet in bytes halved to words
    wire [15:0] maxW  = {9'h000, desc_r[tEp][`DESC_MPK_HI:`DESC_MPK_LO]} >> 1;
    wire [15:0] tRd   = rdOff_r[tEp];
    wire [15:0] tWr   = wrOff_r[tEp];
    wire [15:0] avail = (tWr >= tRd) ? tWr - tRd : tWr + size_r[tEp] - tRd;
    wire        fRdy;
    wire        rxTake = rxValid && rxReady_r;
    wire        gReg   = (regAddr[6] == `A_GLOBAL);

    ep_fifo #(.W(17), .D(FIFO_DEPTH), .AW(FIFO_AW)) txq (
        .clk      (core_clk),
        .rst      (rst),
        .inValid  (pushV),
        .inReady  (fRdy),
        .inData   ({cnt_r == 16'h0001, memRdata}),
        .outValid (txValid),
        .outReady (txReady),
        .outData  ({txLast, txData})
    );

    always @* begin
        pushV = (st_r == S_IN) && memReq_r && memAck;
    end

    always @(posedge core_clk) begin
        if (rst) begin
            st_r <= S_IDLE;
            ep_r <= 3'd0;
            ptr_r <= `RST_OFF;
            cnt_r <= 16'h0000;
            coll_r <= 1'b0;
            outLast_r <= 1'b0;
            half_r <= 1'b0;
            hi_r <= 8'h00;
            dl_r <= 2'd0;
            firmwareMode_r <= 1'b0;
            busAttach_r <= 1'b1;
            detCnt_r <= 16'h0000;
            regRdData_r <= 18'h00000;
            rxReady_r <= 1'b0;
            hsAck_r <= 1'b0;
            hsNak_r <= 1'b0;
            ep0Done_r <= 1'b0;
            memReq_r <= 1'b0;
            memWe_r <= 1'b0;
            memAddr_r <= 18'h00000;
            memWdata_r <= 16'h0000;
            memByteEn_r <= 2'b00;
            pmWe_r <= 1'b0;
            pmAddr_r <= 16'h0000;
            pmData_r <= 24'h000000;
            for (i = 0; i < 8; i = i + 1) begin
                desc_r[i] <= 8'h00;
                base_r[i] <= 18'h00000;
                size_r[i] <= 16'h0000;
                rdOff_r[i] <= `RST_OFF;
                wrOff_r[i] <= `RST_OFF;
                nakLim_r[i] <= 4'h0;
                nakCnt_r[i] <= 4'h0;
                init_r[i] <= 5'h00;
            end
            for (i = 0; i < 3; i = i + 1)
                dlAddr_r[i] <= 16'h0000;
        end else begin
            hsAck_r <= 1'b0;
            hsNak_r <= 1'b0;
            ep0Done_r <= 1'b0;
            pmWe_r <= 1'b0;
            // detach then reattach with new personality
            if (detCnt_r != 16'h0000) begin
                detCnt_r <= detCnt_r - 16'h0001;
                if (detCnt_r == 16'h0001) begin
                    busAttach_r <= 1'b1;
                    firmwareMode_r <= fwLoaded;
                end
            end
            if (regRd) begin
                if (gReg && regAddr[5:0] == `A_STATUS)
                    regRdData_r <= {14'h0000, st_r != S_IDLE, !busAttach_r, busAttach_r, firmwareMode_r};
                else if (gReg && regAddr[5:0] >= `A_DLADDR1 && regAddr[5:0] <= `A_DLADDR3)
                    regRdData_r <= {2'b00, dlAddr_r[regAddr[1:0] - 2'd1]};
                else if (gReg)
                    regRdData_r <= 18'h00000;
                else if (regAddr[2:0] == `F_DESC)
                    regRdData_r <= {10'h000, desc_r[regAddr[5:3]]};
                else if (regAddr[2:0] == `F_BASE)
                    regRdData_r <= base_r[regAddr[5:3]];
                else if (regAddr[2:0] == `F_SIZE)
                    regRdData_r <= {2'b00, size_r[regAddr[5:3]]};
                else if (regAddr[2:0] == `F_RDOFF)
                    regRdData_r <= {2'b00, rdOff_r[regAddr[5:3]]};
                else if (regAddr[2:0] == `F_WROFF)
                    regRdData_r <= {2'b00, wrOff_r[regAddr[5:3]]};
                else if (regAddr[2:0] == `F_NAKLIM)
                    regRdData_r <= {14'h0000, nakLim_r[regAddr[5:3]]};
                else
                    regRdData_r <= 18'h00000;
            end
            if (regWr) begin
                if (gReg && regAddr[5:0] == `A_CTRL) begin
                    busAttach_r <= 1'b0;
                    detCnt_r <= DETACH_CYCLES[15:0];
                end else if (gReg && regAddr[5:0] >= `A_DLADDR1 && regAddr[5:0] <= `A_DLADDR3)
                    dlAddr_r[regAddr[1:0] - 2'd1] <= regWrData[15:0];
                else if (!gReg && regAddr[2:0] == `F_DESC) begin
                    desc_r[regAddr[5:3]] <= regWrData[7:0];
                    init_r[regAddr[5:3]][0] <= 1'b1;
                end else if (!gReg && regAddr[2:0] == `F_BASE) begin
                    base_r[regAddr[5:3]] <= regWrData;
                    init_r[regAddr[5:3]][1] <= 1'b1;
                end else if (!gReg && regAddr[2:0] == `F_SIZE) begin
                    size_r[regAddr[5:3]] <= regWrData[15:0];
                    init_r[regAddr[5:3]][2] <= 1'b1;
                end else if (!gReg && regAddr[2:0] == `F_RDOFF) begin
                    rdOff_r[regAddr[5:3]] <= regWrData[15:0];
                    init_r[regAddr[5:3]][3] <= 1'b1;
                end else if (!gReg && regAddr[2:0] == `F_WROFF) begin
                    wrOff_r[regAddr[5:3]] <= regWrData[15:0];
                    init_r[regAddr[5:3]][4] <= 1'b1;
                end else if (!gReg && regAddr[2:0] == `F_NAKLIM)
                    nakLim_r[regAddr[5:3]] <= regWrData[3:0];
            end
            case (st_r)
            S_IDLE: begin
                if (ep0Req) begin
                    memReq_r <= 1'b1;
                    memWe_r <= 1'b1;
                    memAddr_r <= ep0Addr;
                    memWdata_r <= ep0Data;
                    memByteEn_r <= ep0ByteEn;
                    st_r <= S_EP0;
                end else if (tokenValid && tDl && !tokenIn) begin
                    if (firmwareMode_r) begin
                        dl_r <= tokenEp[1:0] - 2'd1;
                        half_r <= 1'b0;
                        rxReady_r <= 1'b1;
                        st_r <= S_DL;
                    end else
                        hsNak_r <= 1'b1;
                end else if (tokenValid && tGen && firmwareMode_r && init_r[tEp] == `INIT_ALL) begin
                    ep_r <= tEp;
                    coll_r <= 1'b0;
                    outLast_r <= 1'b0;
                    if (!tokenIn) begin
                        ptr_r <= tWr;
                        rxReady_r <= 1'b1;
                        st_r <= S_OUT;
                    end else if (avail >= maxW && maxW != 16'h0000) begin
                        ptr_r <= tRd;
                        cnt_r <= maxW;
                        st_r <= S_IN;
                    end else if (avail != 16'h0000 && nakCnt_r[tEp] >= nakLim_r[tEp]) begin
                        ptr_r <= tRd;
                        cnt_r <= avail;
                        st_r <= S_IN;
                    end else begin
                        hsNak_r <= 1'b1;
                        if (avail != 16'h0000 && nakCnt_r[tEp] != 4'hF)
                            nakCnt_r[tEp] <= nakCnt_r[tEp] + 4'h1;
                    end
                end else if (tokenValid && tokenEp != 4'h0)
                    hsNak_r <= 1'b1;
            end
            S_EP0: begin
                if (memAck) begin
                    memReq_r <= 1'b0;
                    ep0Done_r <= 1'b1;
                    st_r <= S_IDLE;
                end
            end
            S_OUT: begin
                if (rxTake) begin
                    if (coll_r || ptrN == rdC)
                        coll_r <= 1'b1;
                    else begin
                        memReq_r <= 1'b1;
                        memWe_r <= 1'b1;
                        memAddr_r <= mAddr;
                        memWdata_r <= rxData;
                        memByteEn_r <= 2'b11;
                        rxReady_r <= 1'b0;
                        ptr_r <= ptrN;
                    end
                    // no max packet limit on length
                    if (rxLast) begin
                        rxReady_r <= 1'b0;
                        outLast_r <= 1'b1;
                        if (coll_r || ptrN == rdC) begin
                            hsNak_r <= 1'b1;
                            st_r <= S_IDLE;
                        end
                    end
                end else if (memReq_r && memAck) begin
                    memReq_r <= 1'b0;
                    // no more words once the last one is in
                    if (!outLast_r)
                        rxReady_r <= 1'b1;
                end
            end
            S_IN: begin
                if (memReq_r && memAck) begin
                    memReq_r <= 1'b0;
                    ptr_r <= ptrN;
                    cnt_r <= cnt_r - 16'h0001;
                    if (cnt_r == 16'h0001)
                        st_r <= S_INW;
                end else if (!memReq_r && fRdy) begin
                    memReq_r <= 1'b1;
                    memWe_r <= 1'b0;
                    memAddr_r <= mAddr;
                    memByteEn_r <= 2'b11;
                end
            end
            S_INW: begin
                // read offset moves only on ack
                if (hostAck) begin
                    rdOff_r[ep_r] <= ptr_r;
                    nakCnt_r[ep_r] <= 4'h0;
                    st_r <= S_IDLE;
                end else if (hostTimeout)
                    st_r <= S_IDLE;
            end
            S_DL: begin
                if (rxTake) begin
                    half_r <= !half_r;
                    if (!half_r)
                        hi_r <= rxData[15:8];
                    else begin
                        pmWe_r <= 1'b1;
                        pmAddr_r <= dlAddr_r[dl_r];
                        pmData_r <= {hi_r, rxData[7:0], rxData[15:8]};
                        dlAddr_r[dl_r] <= dlAddr_r[dl_r] + 16'h0001;
                    end
                    if (rxLast) begin
                        rxReady_r <= 1'b0;
                        hsAck_r <= 1'b1;
                        st_r <= S_IDLE;
                    end
                end
            end
            default: st_r <= S_IDLE;
            endcase
            // ack and commit once last word stored
            if (st_r == S_OUT && !coll_r && !rxReady_r && !memReq_r && !rxTake && outLast_r) begin
                hsAck_r <= 1'b1;
                wrOff_r[ep_r] <= ptr_r;
                st_r <= S_IDLE;
            end
        end
    end
endmodule // ep_ring_engine

// ===== tb/ep_ring_checker.sv
// port-level assertions for the endpoint ring engine
`timescale 1ns/1ps
`include "ep_ring_regs.vh"
module ep_ring_checker #(
    parameter int DETACH_CYCLES = 20
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        regWr,
    input wire logic [6:0]  regAddr,
    input wire logic        busAttach_r,
    input wire logic        firmwareMode_r,
    input wire logic        rxValid,
    input wire logic        rxLast,
    input wire logic        rxReady_r,
    input wire logic        hsAck_r,
    input wire logic        hsNak_r,
    input wire logic        txValid,
    input wire logic [15:0] txData,
    input wire logic        txReady,
    input wire logic        memReq_r,
    input wire logic        memWe_r,
    input wire logic [17:0] memAddr_r,
    input wire logic [1:0]  memByteEn_r,
    input wire logic        memAck,
    input wire logic        pmWe_r,
    input wire logic        ep0Req
);
    localparam int RE_MAX = DETACH_CYCLES + 8;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_hs_exclusive: assert property (!(hsAck_r && hsNak_r))
        else $error("ack and nak together");
    a_out_answer: assert property (rxValid && rxLast && rxReady_r |-> ##[0:60] (hsAck_r || hsNak_r))
        else $error("out packet never answered");
    a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("tx word dropped while stalled");
    a_mem_hold: assert property (memReq_r && !memAck |=> memReq_r && $stable(memAddr_r))
        else $error("memory request released early");
    a_word_only: assert property (memReq_r && memWe_r && !ep0Req |-> memByteEn_r == 2'h3)
        else $error("generic write not a whole word");
    a_pm_fw: assert property (pmWe_r |-> firmwareMode_r)
        else $error("program write in setup personality");
    a_boot_setup: assert property (disable iff (1'b0) rst |=> !firmwareMode_r)
        else $error("reset left firmware personality");
    a_ctrl_detach: assert property (regWr && regAddr == {`A_GLOBAL, `A_CTRL} |-> ##[1:4] !busAttach_r)
        else $error("control write did not detach");
    a_bus_reattach: assert property ($fell(busAttach_r) |-> ##[1:RE_MAX] busAttach_r)
        else $error("no reattach after detach");

    c_ack: cover property (hsAck_r);
    c_nak: cover property (hsNak_r);
    c_detach: cover property ($fell(busAttach_r));
endmodule // ep_ring_checker

bind ep_ring_engine ep_ring_checker #(.DETACH_CYCLES(DETACH_CYCLES)) u_ep_ring_checker (
    .core_clk(core_clk), .rst(rst), .regWr(regWr), .regAddr(regAddr), .busAttach_r(busAttach_r),
    .firmwareMode_r(firmwareMode_r), .rxValid(rxValid), .rxLast(rxLast), .rxReady_r(rxReady_r),
    .hsAck_r(hsAck_r), .hsNak_r(hsNak_r), .txValid(txValid), .txData(txData), .txReady(txReady),
    .memReq_r(memReq_r), .memWe_r(memWe_r), .memAddr_r(memAddr_r), .memByteEn_r(memByteEn_r),
    .memAck(memAck), .pmWe_r(pmWe_r), .ep0Req(ep0Req));

// ===== tb/dsp_mem_model.sv
// behavioural dsp data memory answering the engine's requests
`timescale 1ns/1ps
module dsp_mem_model #(
    parameter int SLOW = 0
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        memReq,
    input  wire logic        memWe,
    input  wire logic [17:0] memAddr,
    input  wire logic [15:0] memWdata,
    input  wire logic [1:0]  memByteEn,
    output logic [15:0]      memRdata,
    output logic             memAck
);
    logic [15:0] mem [0:1023];
    int          cnt;
    always @(posedge clk) begin
        if (rst) begin
            memAck <= 1'b0;
            cnt <= 0;
            memRdata <= 16'h5A5A;
        end else if (memReq && !memAck && cnt >= SLOW) begin
            memAck <= 1'b1;
            cnt <= 0;
            if (memWe && memByteEn[0]) mem[memAddr[9:0]][7:0] <= memWdata[7:0];
            if (memWe && memByteEn[1]) mem[memAddr[9:0]][15:8] <= memWdata[15:8];
            memRdata <= mem[memAddr[9:0]];
        end else begin
            memAck <= 1'b0;
            cnt <= memReq ? cnt + 1 : 0;
            // released bus inverts the last word every cycle, so it shows again every second cycle
            memRdata <= ~memRdata;
        end
    end
endmodule // dsp_mem_model

// ===== tb/usb_endpoint_ring_buffer_dma_tb.sv
// self-checking bench for the endpoint ring engine
`timescale 1ns/1ps
`include "ep_ring_regs.vh"
module usb_endpoint_ring_buffer_dma_tb;
    logic core_clk = 0, rst = 1, regWr = 0, regRd = 0, fwLoaded = 0, tokenValid = 0, tokenIn = 0;
    logic rxValid = 0, rxLast = 0, txReady = 0, hostAck = 0, memReq, memWe, memAck, txValid, txLast;
    logic [6:0] regAddr = 0;
    logic [17:0] regWrData = 0, regRdData, memAddr, ep0Addr = 0;
    logic [3:0] tokenEp = 0;
    logic [15:0] rxData = 0, txData, memWdata, memRdata, ep0Data = 0;
    logic [1:0] memByteEn, hs, ep0ByteEn = 0;
    logic busAttach, fwMode, rxReady, hsAck, hsNak, ep0Done, ep0Req = 0;
    logic [17:0] q;
    int n_mismatch = 0, n_checks = 0, i, k;
    typedef struct {logic [6:0] a; logic [17:0] d; logic [17:0] e;} row_t;

    always #50 core_clk = ~core_clk;

    ep_ring_engine #(.DETACH_CYCLES(20)) u_ep_ring_engine (
        .core_clk(core_clk), .rst(rst), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData_r(regRdData), .fwLoaded(fwLoaded), .busAttach_r(busAttach),
        .firmwareMode_r(fwMode), .tokenValid(tokenValid), .tokenEp(tokenEp), .tokenIn(tokenIn),
        .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .rxReady_r(rxReady), .hsAck_r(hsAck),
        .hsNak_r(hsNak), .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady),
        .hostAck(hostAck), .hostTimeout(1'b0), .ep0Req(ep0Req), .ep0Addr(ep0Addr), .ep0Data(ep0Data),
        .ep0ByteEn(ep0ByteEn), .ep0Done_r(ep0Done), .memReq_r(memReq), .memWe_r(memWe), .memAddr_r(memAddr),
        .memWdata_r(memWdata), .memByteEn_r(memByteEn), .memRdata(memRdata), .memAck(memAck),
        .pmWe_r(), .pmAddr_r(), .pmData_r());
    dsp_mem_model u_dsp_mem_model (.clk(core_clk), .rst(rst), .memReq(memReq), .memWe(memWe),
        .memAddr(memAddr), .memWdata(memWdata), .memByteEn(memByteEn), .memRdata(memRdata), .memAck(memAck));

    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [6:0] ra(input int ep, input logic [2:0] f);
        return {1'b0, 3'(ep - 4), f};
    endfunction
    task automatic wr(input logic [6:0] a, input logic [17:0] d);
        @(negedge core_clk);
        regWr = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge core_clk);
        regWr = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [17:0] d);
        @(negedge core_clk);
        regRd = 1'b1;
        regAddr = a;
        @(negedge core_clk);
        regRd = 1'b0;
        d = regRdData;
    endtask
    // all five registers, ring kept inside address space
    task automatic cfg(input int ep, input logic [17:0] desc, input logic [17:0] base);
        wr(ra(ep, `F_DESC), desc);
        wr(ra(ep, `F_BASE), base);
        wr(ra(ep, `F_SIZE), 18'h00010);
        wr(ra(ep, `F_RDOFF), 18'h00000);
        wr(ra(ep, `F_WROFF), 18'h00000);
    endtask
    task automatic out_pkt(input int ep, input int n, output logic [1:0] r);
        int j;
        @(negedge core_clk);
        tokenValid = 1'b1;
        tokenEp = 4'(ep);
        tokenIn = 1'b0;
        @(negedge core_clk);
        tokenValid = 1'b0;
        for (j = 0; j < n; j++) begin
            rxValid = 1'b1;
            rxData = 16'hA000 + 16'(j);
            rxLast = (j == n - 1);
            // ready only moves on the edge, so it is read between edges
            while (rxReady !== 1'b1) @(negedge core_clk);
            @(negedge core_clk);
        end
        rxValid = 1'b0;
        rxLast = 1'b0;
        for (j = 0; j < 100 && !(hsAck === 1'b1 || hsNak === 1'b1); j++) @(negedge core_clk);
        r = {hsAck, hsNak};
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        row_t rows [0:4];
        rows = '{'{ra(4, `F_BASE), 18'h3FFFF, 18'h3FFFF}, '{ra(11, `F_SIZE), 18'h3ABCD, 18'h0ABCD},
                 '{ra(7, `F_BASE), 18'h00100, 18'h00100}, '{ra(6, `F_RDOFF), 18'h00005, 18'h00005},
                 '{ra(9, `F_WROFF), 18'h0FFFF, 18'h0FFFF}};
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        chk("attach", 18'h1, {17'h0, busAttach});
        chk("fwMode", 18'h0, {17'h0, fwMode});
        for (i = 4; i <= 11; i++) begin
            rd(ra(i, `F_RDOFF), q);
            chk("rdoff reset", 18'h0, q);
            rd(ra(i, `F_WROFF), q);
            chk("wroff reset", 18'h0, q);
        end
        foreach (rows[r]) begin
            wr(rows[r].a, rows[r].d);
            rd(rows[r].a, q);
            chk("readback", rows[r].e, q);
        end
        out_pkt(1, 0, hs);
        chk("dl refused", 18'h1, {16'h0, hs});
        u_dsp_mem_model.mem[768] = 16'hFFFF;
        @(negedge core_clk);
        ep0Req = 1'b1;
        ep0Addr = 18'h00300;
        ep0Data = 16'h1234;
        ep0ByteEn = 2'b01;
        while (ep0Done !== 1'b1) @(negedge core_clk);
        ep0Req = 1'b0;
        chk("ep0 byte", 18'h0FF34, {2'b0, u_dsp_mem_model.mem[768]});
        // generic endpoints only answer in the firmware personality
        fwLoaded = 1'b1;
        wr({`A_GLOBAL, `A_CTRL}, 18'h00001);
        chk("detach", 18'h0, {17'h0, busAttach});
        repeat (40) @(negedge core_clk);
        chk("reattach", 18'h1, {17'h0, busAttach});
        chk("fw mode", 18'h1, {17'h0, fwMode});
        // out endpoint, 8-byte packets, 16-word ring at 0x100
        cfg(4, 18'h00010, 18'h00100);
        out_pkt(4, 4, hs);
        chk("ack4", 18'h2, {16'h0, hs});
        rd(ra(4, `F_WROFF), q);
        chk("wroff4", 18'h4, q);
        for (i = 0; i < 4; i++) chk("mem", 18'(16'hA000 + i), {2'b0, u_dsp_mem_model.mem[256 + i]});
        out_pkt(4, 12, hs);
        chk("nak", 18'h1, {16'h0, hs});
        rd(ra(4, `F_WROFF), q);
        chk("wroff kept", 18'h4, q);
        wr(ra(4, `F_RDOFF), 18'h00004);
        out_pkt(4, 12, hs);
        chk("oversize ack", 18'h2, {16'h0, hs});
        rd(ra(4, `F_WROFF), q);
        chk("wroff wrap", 18'h0, q);
        // in endpoint: dsp fills four words then publishes
        cfg(5, 18'h00011, 18'h00200);
        for (i = 0; i < 4; i++) u_dsp_mem_model.mem[512 + i] = 16'hB000 + 16'(i);
        wr(ra(5, `F_WROFF), 18'h00004);
        @(negedge core_clk);
        tokenValid = 1'b1;
        tokenEp = 4'h5;
        tokenIn = 1'b1;
        txReady = 1'b1;
        @(negedge core_clk);
        tokenValid = 1'b0;
        k = 0;
        for (i = 0; i < 200 && k < 5; i++) begin
            if (txValid === 1'b1) begin
                chk("txData", 18'(16'hB000 + k), {2'b0, txData});
                k++;
                if (txLast === 1'b1) break;
            end
            @(negedge core_clk);
        end
        @(negedge core_clk);
        txReady = 1'b0;
        chk("txCount", 18'h4, 18'(k));
        rd(ra(5, `F_RDOFF), q);
        chk("rdoff before ack", 18'h0, q);
        @(negedge core_clk);
        hostAck = 1'b1;
        @(negedge core_clk);
        hostAck = 1'b0;
        rd(ra(5, `F_RDOFF), q);
        chk("rdoff after ack", 18'h4, q);
        wr(ra(5, `F_NAKLIM), 18'h00001);
        wr(ra(5, `F_WROFF), 18'h00006);
        for (k = 0; k < 2; k++) begin
            @(negedge core_clk);
            tokenValid = 1'b1;
            @(negedge core_clk);
            tokenValid = 1'b0;
            chk("short nak", {17'h0, k == 0}, {17'h0, hsNak});
        end
        repeat (8) @(negedge core_clk);
        chk("short sent", 18'h1, {17'h0, txValid});
        end_sim();
    end
endmodule // usb_endpoint_ring_buffer_dma_tb
